/* hw/link_gate.sv */
// Purpose: init gating and transmit stream gating for a serial link core
// Assumes: partner logic honours valid/ready and the init prerequisites
// Notes: registers reached over Avalon-MM, answered in one wait cycle
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

// Function
// - init never completes while the pll unlock indication is high.
// - in simplex timer mode an rx reset also resets tx so init resends.
// - a pending pause or priority request holds off normal transmit data.
// - with pause enabled an XOFF stops normal data until an XON arrives.
// - the byte mask counts only on the last beat and is ignored elsewhere.
// - receive data and framing are meaningful only while rx valid is high.
// - only continuous streams are supported and the mask is read on last.
module link_gate #(
	parameter int LANES = link_gate_pkg::LANES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pll_unlock,
	input wire logic power_down,
	input wire logic init_req,
	input wire logic rx_reset,
	input wire logic tx_reset_in,
	input wire logic [LANES-1:0] lane_aligned,
	input wire logic pause_req_valid,
	input wire logic prio_req_valid,
	input wire link_gate_pkg::pause_msg_t pause_msg,
	input wire logic tx_tvalid,
	output logic tx_tready,
	input wire link_gate_pkg::beat_t tx_beat,
	output logic link_valid,
	output link_gate_pkg::beat_t link_beat,
	input wire link_gate_pkg::beat_t rx_link_beat,
	input wire logic rx_link_valid,
	output logic rx_tvalid,
	output link_gate_pkg::beat_t rx_beat,
	output logic tx_reset_out,
	output logic [LANES-1:0] lane_ready,
	output logic chan_ready,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	// ----------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// async pins: three stages, change counts when stages two and three agree
	localparam int NSYNC = 4 + LANES;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	assign pin_raw = {lane_aligned, tx_reset_in, rx_reset, init_req,
		pll_unlock | power_down};
	always_comb begin
		pin_d = pin_q;
		for (int i = 0; i < NSYNC; i++)
			if (s2_q[i] == s3_q[i])
				pin_d[i] = s3_q[i];
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end
	logic not_locked, init_hold, rx_rst_s, tx_rst_s;
	logic [LANES-1:0] aligned_s;
	assign not_locked = pin_q[0];
	assign init_hold = pin_q[1];
	assign rx_rst_s = pin_q[2];
	assign tx_rst_s = pin_q[3];
	assign aligned_s = pin_q[NSYNC-1:4];

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [2:0] ctrl_q, ctrl_d;
	logic [31:0] cnt_q, cnt_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic xoff_q, xoff_d;
	logic pause_en, simplex, sw_reset;
	assign pause_en = ctrl_q[link_gate_pkg::CTRL_PAUSE_EN_BIT];
	assign simplex = ctrl_q[link_gate_pkg::CTRL_SIMPLEX_BIT];
	assign sw_reset = ctrl_q[link_gate_pkg::CTRL_SW_RESET_BIT];
	link_gate_pkg::init_state_t st_q, st_d;

	// one wait cycle: the request is answered on the edge after it appears
	// a write lands only on the answering edge, so a master that holds
	// its request until waitrequest is low sees exactly one update
	always_comb begin
		ctrl_d = ctrl_q;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		if (avs_write && ack_q && avs_address == link_gate_pkg::CTRL_OFS)
			ctrl_d = avs_writedata[2:0];
		if ((avs_read || avs_write) && !ack_q) begin
			ack_d = 1'b1;
			case (avs_address)
				link_gate_pkg::CTRL_OFS: rdata_d = {29'h0, ctrl_q};
				link_gate_pkg::STAT_OFS: rdata_d = {16'h0,
					8'(lane_ready), 3'h0, xoff_q, not_locked,
					chan_ready, st_q};
				link_gate_pkg::CNT_OFS: rdata_d = cnt_q;
				default: rdata_d = link_gate_pkg::READ_UNMAPPED;
			endcase
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= link_gate_pkg::CTRL_RESET;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// reset pairing and link-down decode
	// ----------------------------------------
	// any one of these drops the link back to the start of init
	function automatic logic link_down(
		input logic unlock,
		input logic hold,
		input logic swr,
		input logic rst
	);
		return unlock | hold | swr | rst;
	endfunction

	logic tx_rst_q, tx_rst_d;
	logic down;

	// simplex pairs resets
	// in simplex the far receiver only recovers if we resend init
	// patterns, so a local rx reset must drag tx reset with it
	always_comb begin
		tx_rst_d = tx_rst_s | (simplex & rx_rst_s);
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tx_rst_q <= 1'b0;
		else
			tx_rst_q <= tx_rst_d;
	end
	assign tx_reset_out = tx_rst_q;

	// unlock holds init
	// pll unlock and power-down share one synchroniser bit
	assign down = link_down(not_locked, init_hold, sw_reset,
		tx_rst_q | rx_rst_s);

	// ----------------------------------------
	// lane qualification
	// ----------------------------------------
	localparam int QW = $clog2(link_gate_pkg::LANE_QUAL_CYC + 1);
	localparam logic [QW-1:0] QUAL_END = QW'(link_gate_pkg::LANE_QUAL_CYC);

	logic [QW-1:0] qual_q [LANES];
	logic [QW-1:0] qual_d [LANES];
	logic [LANES-1:0] lane_q, lane_d;

	// lane qualify
	// a lane is ready once it has stayed aligned for the whole
	// qualify time; an alignment drop of two cycles or more restarts the count
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			qual_d[i] = qual_q[i];
			lane_d[i] = lane_q[i];
			if (down || !aligned_s[i]) begin
				qual_d[i] = '0;
				lane_d[i] = 1'b0;
			end else if (qual_q[i] != QUAL_END) begin
				qual_d[i] = qual_q[i] + 1'b1;
			end else begin
				lane_d[i] = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LANES; i++)
				qual_q[i] <= '0;
			lane_q <= '0;
		end else begin
			for (int i = 0; i < LANES; i++)
				qual_q[i] <= qual_d[i];
			lane_q <= lane_d;
		end
	end
	assign lane_ready = lane_q;

	// ----------------------------------------
	// channel init state machine
	// ----------------------------------------
	logic chan_q, chan_d;

	// channel after lanes
	// decisions use the next lane state so channel-ready never
	// outlives a lane that drops on the same edge
	always_comb begin
		st_d = st_q;
		case (st_q)
			link_gate_pkg::ST_DOWN: begin
				if (!down && (|lane_d))
					st_d = link_gate_pkg::ST_LANE;
			end
			link_gate_pkg::ST_LANE: begin
				if (down || !(|lane_d))
					st_d = link_gate_pkg::ST_DOWN;
				else if (&lane_d)
					st_d = link_gate_pkg::ST_CHAN;
			end
			link_gate_pkg::ST_CHAN: begin
				if (down || !(&lane_d))
					st_d = link_gate_pkg::ST_DOWN;
			end
			default: st_d = link_gate_pkg::ST_DOWN;
		endcase
		chan_d = (st_d == link_gate_pkg::ST_CHAN) && (&lane_d);
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= link_gate_pkg::ST_DOWN;
			chan_q <= 1'b0;
		end else begin
			st_q <= st_d;
			chan_q <= chan_d;
		end
	end
	assign chan_ready = chan_q;

	// ----------------------------------------
	// pause state from the partner
	// ----------------------------------------
	// xoff until xon
	// clearing pause enable also frees the channel, so software can
	// recover from a partner that never sends its XON
	always_comb begin
		xoff_d = xoff_q;
		if (!pause_en || pause_msg == link_gate_pkg::MSG_XON)
			xoff_d = 1'b0;
		else if (pause_msg == link_gate_pkg::MSG_XOFF)
			xoff_d = 1'b1;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			xoff_q <= 1'b0;
		else
			xoff_q <= xoff_d;
	end

	// ----------------------------------------
	// transmit gating and link beat
	// ----------------------------------------
	// gate tx ready
	// flow-control requests own the channel while they are pending
	assign tx_tready = chan_q && !pause_req_valid && !prio_req_valid &&
		!xoff_q;

	logic take;
	assign take = tx_tvalid && tx_tready;

	link_gate_pkg::beat_t lbeat_q, lbeat_d;
	logic lvalid_q, lvalid_d;

	// mask on last
	// mid-packet beats always carry every byte, whatever the mask says
	always_comb begin
		lvalid_d = take;
		lbeat_d = lbeat_q;
		if (take) begin
			lbeat_d = tx_beat;
			if (!tx_beat.last)
				lbeat_d.keep = '1;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvalid_q <= 1'b0;
			lbeat_q <= '0;
		end else begin
			lvalid_q <= lvalid_d;
			lbeat_q <= lbeat_d;
		end
	end
	assign link_valid = lvalid_q;
	assign link_beat = lbeat_q;

	// accepted beat count; wraps silently after 2^32 beats
	always_comb begin
		cnt_d = cnt_q;
		if (take)
			cnt_d = cnt_q + 32'h1;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_d;
	end

	// ----------------------------------------
	// receive path
	// ----------------------------------------
	link_gate_pkg::beat_t rbeat_q, rbeat_d;
	logic rvalid_q, rvalid_d;

	// rx valid qualifies
	// the beat only moves with valid, so idle junk from the lanes
	// never reaches the user side
	always_comb begin
		rvalid_d = rx_link_valid && chan_q;
		rbeat_d = rbeat_q;
		if (rx_link_valid && chan_q)
			rbeat_d = rx_link_beat;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rbeat_q <= '0;
		end else begin
			rvalid_q <= rvalid_d;
			rbeat_q <= rbeat_d;
		end
	end
	assign rx_tvalid = rvalid_q;
	assign rx_beat = rbeat_q;
endmodule

/* hw/link_gate_pkg.sv */
// Purpose: shared constants and carriers for the user stream gating block
// Assumes: 32-bit Avalon-MM register access, one 20 MHz clock
// Notes: byte addresses are word aligned
package link_gate_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int DATA_W = 32;
	localparam int KEEP_W = DATA_W / 8;
	localparam int LANES = 2;
	// register byte offsets
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] CNT_OFS = 4'h8;
	// control field positions
	localparam int CTRL_PAUSE_EN_BIT = 0;
	localparam int CTRL_SIMPLEX_BIT = 1;
	localparam int CTRL_SW_RESET_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	// lane-ready qualification time in ns and its cycle count
	localparam int LANE_QUAL_NS = 400;
	localparam int LANE_QUAL_CYC =
		(LANE_QUAL_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [31:0] READ_UNMAPPED = 32'hDEADBEEF;

	// pause message from the partner
	typedef enum logic [1:0] {
		MSG_NONE = 2'b00,
		MSG_XOFF = 2'b01,
		MSG_XON = 2'b10
	} pause_msg_t;

	typedef enum logic [1:0] {
		ST_DOWN = 2'b00,
		ST_LANE = 2'b01,
		ST_CHAN = 2'b10
	} init_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [KEEP_W-1:0] keep;
		logic last;
	} beat_t;
endpackage

/* dv/link_gate_props.sv */
// Purpose: port checks on init gating, tx gating and bus answer
// Assumes: pause enable stays at its reset value while pausing
// Notes: one clock domain
`timescale 1ns/1ps
module link_gate_props #(parameter int LANES = 2) (
	input wire logic ref_clk, rstn, pll_unlock, pause_req_valid,
	input wire logic prio_req_valid, tx_tready, chan_ready,
	input wire logic avs_read, avs_waitrequest,
	input wire logic [LANES-1:0] lane_ready,
	input wire link_gate_pkg::pause_msg_t pause_msg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// unlock crosses a three-stage synchroniser, then state and flops
	property p_u; pll_unlock[*6] |-> !chan_ready; endproperty
	a_u: assert property (p_u) else $error("chan up unlocked");
	property p_l; pll_unlock[*6] |-> !lane_ready; endproperty
	a_l: assert property (p_l) else $error("lane up unlocked");
	property p_c; chan_ready |-> &lane_ready; endproperty
	a_c: assert property (p_c) else $error("chan before lanes");
	property p_t; tx_tready |-> chan_ready; endproperty
	a_t: assert property (p_t) else $error("ready without chan");
	property p_p; pause_req_valid[*2] |-> !tx_tready; endproperty
	a_p: assert property (p_p) else $error("data in pause");
	property p_r; prio_req_valid[*2] |-> !tx_tready; endproperty
	a_r: assert property (p_r) else $error("data in prio");
	property p_x; pause_msg == link_gate_pkg::MSG_XOFF ##1
		pause_msg != link_gate_pkg::MSG_XON [*2] |-> !tx_tready; endproperty
	a_x: assert property (p_x) else $error("data after stop");
	property p_a; avs_read |-> ##[0:2] !avs_waitrequest; endproperty
	a_a: assert property (p_a) else $error("no bus answer");
endmodule
bind link_gate link_gate_props #(.LANES(LANES)) u_props(.*);

/* dv/link_partner.sv */
// Purpose: far channel partner, loops the link back to rx
// Assumes: lanes align once up is set
// Notes: idle beat is junk so misuse shows
`timescale 1ns/1ps
module link_partner (
	input wire logic ref_clk, up, link_valid,
	input wire link_gate_pkg::beat_t link_beat,
	output logic [1:0] lane_aligned,
	output logic rx_link_valid,
	output link_gate_pkg::beat_t rx_link_beat
);
	assign lane_aligned = {2{up}};
	always @(posedge ref_clk) begin
		rx_link_valid <= link_valid;
		rx_link_beat <= link_valid ? link_beat : ~rx_link_beat;
	end
endmodule

/* dv/tb_top.sv */
// Purpose: bench for link_gate
// Assumes: 20 MHz ref_clk
// Notes: partner loops link back
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 0, rstn = 0, pll_unlock = 1, up = 0, tx_tvalid = 0;
	logic power_down = 0, init_req = 0, rx_reset = 0, tx_reset_in = 0;
	logic pause_req_valid = 0, prio_req_valid = 0, avs_read = 0;
	logic avs_write = 0, tx_tready, link_valid, rx_link_valid, rx_tvalid;
	logic tx_reset_out, chan_ready, avs_waitrequest;
	logic [1:0] lane_aligned, lane_ready;
	logic [3:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, got;
	link_gate_pkg::pause_msg_t pause_msg = link_gate_pkg::MSG_NONE;
	// last beat carries a non-zero mask
	link_gate_pkg::beat_t tx_beat = '{32'hA5C3, 4'h3, 1'h1};
	link_gate_pkg::beat_t link_beat, rx_link_beat, rx_beat;
	int n_errors = 0, checks = 0;
	always #25 ref_clk = ~ref_clk;
	link_gate u_dut(.*);
	link_partner u_p(.*);
	task w(int n); repeat (n) @(posedge ref_clk); endtask
	task chk(input logic [63:0] g, e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one Avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_read <= !wr; avs_write <= wr; avs_address <= a; avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		got = avs_readdata; avs_read <= 0; avs_write <= 0; w(1);
	endtask
	initial begin
		// power_down and init_req stay low, clock runs from start
		w(4); rstn <= 1; w(3); up <= 1; w(20);
		chk(chan_ready, 1'h0);
		pll_unlock <= 0;
		for (int i = 0; i < 60 && chan_ready !== 1'b1; i++) w(1);
		chk({chan_ready, lane_ready}, 3'h7);
		pause_req_valid <= 1; prio_req_valid <= 1; tx_tvalid <= 1; w(3);
		chk(tx_tready, 1'h0);
		pause_req_valid <= 0; w(2);
		chk(tx_tready, 1'h0);
		pause_msg <= link_gate_pkg::MSG_XOFF; w(1);
		pause_msg <= link_gate_pkg::MSG_NONE;
		prio_req_valid <= 0; w(3);
		chk(tx_tready, 1'h0);
		pause_msg <= link_gate_pkg::MSG_XON;
		do w(1); while (tx_tready !== 1'b1);
		tx_tvalid <= 0; pause_msg <= link_gate_pkg::MSG_NONE;
		do w(1); while (rx_tvalid !== 1'b1);
		chk(rx_beat, tx_beat);
		bus(0, link_gate_pkg::CTRL_OFS, 32'h0);
		chk(got, link_gate_pkg::CTRL_RESET);
		bus(1, link_gate_pkg::CTRL_OFS, 32'h2);
		bus(0, link_gate_pkg::CTRL_OFS, 32'h0);
		chk(got, 32'h2);
		bus(0, 4'hC, 32'h0);
		chk(got, link_gate_pkg::READ_UNMAPPED);
		bus(0, link_gate_pkg::CNT_OFS, 32'h0);
		chk(got, 32'h1);
		rx_reset <= 1; w(6);
		chk({tx_reset_out, chan_ready}, 2'h2);
		rx_reset <= 0;
		for (int i = 0; i < 60 && chan_ready !== 1'b1; i++) w(1);
		chk({chan_ready, tx_reset_out}, 2'h2);
		close_out;
	end
	initial begin #50000; n_errors++; close_out; end
endmodule
